// file: sec_consts.vh
`ifndef SEC_CONSTS_VH
`define SEC_CONSTS_VH
// ****************************************
// register byte offsets
// ****************************************
`define SEC_OFS_CMD 8'h00
`define SEC_OFS_DATA 8'h04
`define SEC_OFS_ADRL 8'h08
`define SEC_OFS_ADRH 8'h0c
`define SEC_OFS_PCFG 8'h10
`define SEC_OFS_CTRL 8'h14
// ****************************************
// command register fields
// ****************************************
`define SEC_BSY 31
`define SEC_OP_HI 30
`define SEC_OP_LO 28
`define SEC_TOF 9
`define SEC_LDF 8
`define SEC_LOC_HI 6
// ****************************************
// pin config fields
// ****************************************
`define SEC_PC_EN 0
`define SEC_PC_DGPO 1
`define SEC_PC_CGPO 2
`define SEC_PC_DMON 3
`define SEC_PC_CMON 4
`define SEC_PC_RST 5'h01
`define SEC_SRST 0
// ****************************************
// host opcodes
// ****************************************
`define SEC_OP_READ 3'h0
`define SEC_OP_WDIS 3'h1
`define SEC_OP_WEN 3'h2
`define SEC_OP_WRITE 3'h3
`define SEC_OP_WALL 3'h4
`define SEC_OP_ERASE 3'h5
`define SEC_OP_EALL 3'h6
`define SEC_OP_RELOAD 3'h7
// ****************************************
// serial frame codes
// ****************************************
`define SEC_START 1'h1
`define SEC_W_RD 2'h2
`define SEC_W_WR 2'h1
`define SEC_W_ER 2'h3
`define SEC_W_EXT 2'h0
`define SEC_X_WEN 7'h60
`define SEC_X_WDIS 7'h00
`define SEC_X_EALL 7'h40
`define SEC_X_WALL 7'h20
`define SEC_LEN_SHORT 5'h0a
`define SEC_LEN_LONG 5'h12
`define SEC_RD_TAIL 5'h09
`define SEC_SIG 8'ha5
`define SEC_NBYTES 3'h6
// ****************************************
// timing
// ****************************************
`define SEC_CLK_NS 25
`define SEC_SCLK_NS 200
`define SEC_HALF_CYC (`SEC_SCLK_NS / `SEC_CLK_NS / 2)
`define SEC_TO_MS 30
`define SEC_CLK_KHZ 40000
`define SEC_TO_CYC (`SEC_TO_MS * `SEC_CLK_KHZ)
`endif

// file: sec_mem_model.sv
`timescale 1ns/10ps
// ****************************************
// three-wire serial memory, 128 x 8
// ****************************************
module sec_mem_model (
    input wire sclk,
    input wire cs,
    input wire di,
    input wire dead,
    output reg do_o
);
    reg [7:0] mem [0:127];
    reg [17:0] sh;
    reg [4:0] n;
    reg [1:0] op;
    reg [6:0] a;
    reg we;
    reg pend;
    integer i;
    initial
    begin
        we = 1'b0; // powers up write-protected
        n = 5'h0;
        pend = 1'b0;
        do_o = 1'b1;
    end
    always @(posedge sclk)
    if (cs)
    begin
        sh = {sh[16:0], di};
        n = n + 5'h1;
        if (n == 5'h0a)
        begin
            op = sh[8:7];
            a = sh[6:0];
        end
        if (n > 5'h0a && op == 2'h2)
            do_o = mem[a][5'h12 - n];
    end
    // dead holds the ready line low so that only the timeout ends the poll
    always @(posedge cs)
    begin
        n = 5'h0;
        if (pend)
        begin
            do_o = 1'b0;
            if (!dead)
                #400 do_o = 1'b1;
        end
    end
    always @(negedge cs)
    begin
        do_o = ~do_o; // a released line must not keep its old level
        if (n == 5'h0)
            pend = 1'b0;
        else
        begin
            pend = op[0] | (op == 2'h0 && a[6] != a[5]);
            if (op == 2'h0)
                we = (a[6:5] == 2'h3) ? 1'b1 : (a[6:5] == 2'h0) ? 1'b0 : we;
            for (i = 0; i < 128; i = i + 1)
                if (we && ((op == 2'h3 && a == i) || (op == 2'h0 && a[6:5] == 2'h2)))
                    mem[i] = 8'hff;
                else if (we && ((op == 2'h1 && a == i) || (op == 2'h0 && a[6:5] == 2'h1)))
                    mem[i] = sh[7:0];
        end
    end
endmodule

// file: sec_shift.v
`timescale 1ns/10ps
`include "sec_consts.vh"
module sec_shift (
    input wire i_clk_sys,
    input wire i_rst,
    input wire i_ce,
    input wire i_start,
    input wire [17:0] i_tx,
    input wire [4:0] i_len,
    input wire i_rd,
    input wire i_sdi,
    output reg o_sclk,
    output reg o_sdo,
    output reg o_oe,
    output reg o_done,
    output reg [7:0] o_rx
);
    localparam integer HALF_INT = `SEC_HALF_CYC - 1;
    localparam [2:0] HALF_LAST = HALF_INT[2:0];
    reg act_r;
    reg [2:0] div_r;
    reg [17:0] sh_r;
    reg [4:0] cnt_r;

    // data goes out msb first, changes on the falling edge and is sampled
    // at the next fall, which sees what the memory put out at the rise
    always @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            act_r <= 1'b0;
            div_r <= 3'h0;
            sh_r <= 18'h00000;
            cnt_r <= 5'h00;
            o_sclk <= 1'b0;
            o_sdo <= 1'b0;
            o_oe <= 1'b0;
            o_done <= 1'b0;
            o_rx <= 8'h00;
        end
        else if (i_ce)
        begin
            o_done <= 1'b0;
            if (i_start)
            begin
                act_r <= 1'b1;
                sh_r <= i_tx;
                cnt_r <= i_len;
                div_r <= 3'h0;
                o_sclk <= 1'b0;
                o_sdo <= i_tx[17];
                o_oe <= 1'b1;
            end
            else if (act_r)
            begin
                if (div_r == HALF_LAST)
                begin
                    div_r <= 3'h0;
                    if (!o_sclk)
                        o_sclk <= 1'b1;
                    else
                    begin
                        o_sclk <= 1'b0;
                        o_rx <= {o_rx[6:0], i_sdi};
                        cnt_r <= cnt_r - 5'h01;
                        if (cnt_r == 5'h01)
                        begin
                            act_r <= 1'b0;
                            o_done <= 1'b1;
                            o_oe <= 1'b0;
                        end
                        else
                        begin
                            sh_r <= {sh_r[16:0], 1'b0};
                            o_sdo <= sh_r[16];
                            o_oe <= !(i_rd && cnt_r <= `SEC_RD_TAIL);
                        end
                    end
                end
                else
                    div_r <= div_r + 3'h1;
            end
        end
    end
endmodule

// file: sec_sync.v
`timescale 1ns/10ps
`include "sec_consts.vh"
module sec_sync #(
    parameter W = 1
) (
    input wire i_clk_sys,
    input wire i_rst,
    input wire i_ce,
    input wire [W-1:0] i_d,
    output wire [W-1:0] o_q
);
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1)
        begin : g_bit
            reg s1_r;
            reg s2_r;
            always @(posedge i_clk_sys or posedge i_rst)
            begin
                if (i_rst)
                begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                end
                else if (i_ce)
                begin
                    s1_r <= i_d[g];
                    s2_r <= s1_r;
                end
            end
            assign o_q[g] = s2_r;
        end
    endgenerate
endmodule

// file: sec_top.v
//
// Notes on behaviour
// - after reset read byte 0, expect a5
// - then six bytes fill station address, byte0 first
// - set address-loaded flag after six bytes
// - no signature: leave station address untouched
// - reload repeats check; only success sets flag
// - host sets busy; controller clears it when done
// - read byte in data register before busy clears
// - no response in 30 ms: abandon, set timeout
// - interface disabled: pins become outputs or monitors
// - erase clears the addressed byte
// - erase-all starts a bulk erase
// - write-disable makes memory ignore erase and write
// - write-enable allows erase and write
// - read returns addressed byte in data register
// - write stores data register at location
// - write-all stores data register everywhere
// - 10 clocks short commands, 18 for data commands
// - memory is 128 locations of 8 bits
//
// Added by the designer: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps
`include "sec_consts.vh"
module sec_top #(
    parameter TO_CYCLES = `SEC_TO_CYC
) (
    input wire i_clk_sys,
    input wire i_rst,
    input wire i_ce,
    input wire i_hsel,
    input wire [31:0] i_haddr,
    input wire [1:0] i_htrans,
    input wire i_hwrite,
    input wire [2:0] i_hsize,
    input wire [31:0] i_hwdata,
    input wire i_hready,
    output reg o_hreadyout,
    output reg o_hresp,
    output reg [31:0] o_hrdata,
    input wire [1:0] i_mii_mon,
    input wire i_sdat,
    output reg o_sdat,
    output reg o_sdat_oe,
    output reg o_sclk,
    output reg o_scs,
    output reg [47:0] o_station_addr
);
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_SEND = 3'h1;
    localparam [2:0] S_GAP = 3'h2;
    localparam [2:0] S_POLL = 3'h3;
    localparam integer GAP_INT = `SEC_HALF_CYC - 1;
    localparam integer TO_INT = TO_CYCLES - 1;
    localparam [2:0] GAP_LAST = GAP_INT[2:0];
    localparam [20:0] TO_LAST = TO_INT[20:0];

    reg [2:0] st_r;
    reg busy_r;
    reg [2:0] op_r;
    reg [6:0] loc_r;
    reg to_r;
    reg ld_r;
    reg [7:0] data_r;
    reg [4:0] pcfg_r;
    reg boot_r;
    reg loading_r;
    reg [2:0] lidx_r;
    reg [2:0] gap_r;
    reg [20:0] tmo_r;
    reg cs_r;
    reg eng_start_r;
    reg [17:0] eng_tx_r;
    reg [4:0] eng_len_r;
    reg eng_rd_r;
    reg aw_r;
    reg [7:0] aa_r;
    reg [31:0] rmux;
    wire sdi_s;
    wire eng_sclk;
    wire eng_sdo;
    wire eng_oe;
    wire eng_done;
    wire [7:0] eng_rx;
    wire a_sel;
    wire cmd_wr;
    wire rd_op;
    wire poll_op;

    // ****************************************
    // frame build
    // ****************************************
    function [17:0] frame;
        input [2:0] op;
        input [6:0] a;
        input [7:0] d;
        begin
            case (op)
                `SEC_OP_READ, `SEC_OP_RELOAD:
                    frame = {`SEC_START, `SEC_W_RD, a, 8'h00};
                `SEC_OP_WRITE:
                    frame = {`SEC_START, `SEC_W_WR, a, d};
                `SEC_OP_ERASE:
                    frame = {`SEC_START, `SEC_W_ER, a, 8'h00};
                `SEC_OP_EALL:
                    frame = {`SEC_START, `SEC_W_EXT, `SEC_X_EALL, 8'h00};
                `SEC_OP_WALL:
                    frame = {`SEC_START, `SEC_W_EXT, `SEC_X_WALL, d};
                `SEC_OP_WEN:
                    frame = {`SEC_START, `SEC_W_EXT, `SEC_X_WEN, 8'h00};
                default:
                    frame = {`SEC_START, `SEC_W_EXT, `SEC_X_WDIS, 8'h00};
            endcase
        end
    endfunction

    function [4:0] flen;
        input [2:0] op;
        begin
            case (op)
                `SEC_OP_READ, `SEC_OP_RELOAD, `SEC_OP_WRITE, `SEC_OP_WALL:
                    flen = `SEC_LEN_LONG;
                default:
                    flen = `SEC_LEN_SHORT;
            endcase
        end
    endfunction

    assign rd_op = (op_r == `SEC_OP_READ) || (op_r == `SEC_OP_RELOAD);
    // programming commands end with a ready poll; enable and disable do not
    assign poll_op = (op_r == `SEC_OP_WRITE) || (op_r == `SEC_OP_WALL) ||
                     (op_r == `SEC_OP_ERASE) || (op_r == `SEC_OP_EALL);

    // ****************************************
    // pin input and serial engine
    // ****************************************
    sec_sync #(
        .W(1)
    ) sec_sync_inst (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_d(i_sdat),
        .o_q(sdi_s)
    );

    sec_shift sec_shift_inst (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_start(eng_start_r),
        .i_tx(eng_tx_r),
        .i_len(eng_len_r),
        .i_rd(eng_rd_r),
        .i_sdi(sdi_s),
        .o_sclk(eng_sclk),
        .o_sdo(eng_sdo),
        .o_oe(eng_oe),
        .o_done(eng_done),
        .o_rx(eng_rx)
    );

    // ****************************************
    // bus slave
    // ****************************************
    assign a_sel = i_hsel && i_htrans[1] && i_hready;
    assign cmd_wr = aw_r && (aa_r == `SEC_OFS_CMD);

    always @*
    begin
        case (i_haddr[7:0])
            `SEC_OFS_CMD:
                rmux = {busy_r, op_r, 18'h00000, to_r, ld_r, 1'b0, loc_r};
            `SEC_OFS_DATA:
                rmux = {24'h000000, data_r};
            `SEC_OFS_ADRL:
                rmux = o_station_addr[31:0];
            `SEC_OFS_ADRH:
                rmux = {16'h0000, o_station_addr[47:32]};
            `SEC_OFS_PCFG:
                rmux = {27'h0000000, pcfg_r};
            default:
                rmux = 32'h00000000;
        endcase
    end

    // zero wait states: read data is registered in the address phase
    always @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            aw_r <= 1'b0;
            aa_r <= 8'h00;
            o_hrdata <= 32'h00000000;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end
        else if (i_ce)
        begin
            aw_r <= a_sel && i_hwrite;
            if (a_sel)
                aa_r <= i_haddr[7:0];
            if (a_sel && !i_hwrite)
                o_hrdata <= rmux;
        end
    end

    // ****************************************
    // control and sequencing
    // ****************************************
    always @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_r <= S_IDLE;
            busy_r <= 1'b0;
            op_r <= `SEC_OP_READ;
            loc_r <= 7'h00;
            to_r <= 1'b0;
            ld_r <= 1'b0;
            data_r <= 8'h00;
            pcfg_r <= `SEC_PC_RST;
            boot_r <= 1'b1;
            loading_r <= 1'b0;
            lidx_r <= 3'h0;
            gap_r <= 3'h0;
            tmo_r <= 21'h000000;
            cs_r <= 1'b0;
            eng_start_r <= 1'b0;
            eng_tx_r <= 18'h00000;
            eng_len_r <= 5'h00;
            eng_rd_r <= 1'b0;
            o_station_addr <= 48'h000000000000;
        end
        else if (i_ce)
        begin
            eng_start_r <= 1'b0;
            // register writes; while busy the command word and data are locked
            if (aw_r)
            begin
                case (aa_r)
                    `SEC_OFS_CMD:
                    begin
                        if (!busy_r)
                        begin
                            op_r <= i_hwdata[`SEC_OP_HI:`SEC_OP_LO];
                            loc_r <= i_hwdata[`SEC_LOC_HI:0];
                            busy_r <= i_hwdata[`SEC_BSY];
                        end
                    end
                    `SEC_OFS_DATA:
                        if (!busy_r)
                            data_r <= i_hwdata[7:0];
                    `SEC_OFS_ADRL:
                        if (!busy_r)
                            o_station_addr[31:0] <= i_hwdata;
                    `SEC_OFS_ADRH:
                        if (!busy_r)
                            o_station_addr[47:32] <= i_hwdata[15:0];
                    `SEC_OFS_PCFG:
                        pcfg_r <= i_hwdata[4:0];
                    `SEC_OFS_CTRL:
                        if (i_hwdata[`SEC_SRST])
                            boot_r <= 1'b1;
                    default:
                        boot_r <= boot_r;
                endcase
            end
            // timeout is write-one-to-clear; a set later in this block wins
            if (cmd_wr && i_hwdata[`SEC_TOF])
                to_r <= 1'b0;

            case (st_r)
                S_IDLE:
                begin
                    if (boot_r)
                    begin
                        // soft or hard reset: run the load as an internal reload
                        boot_r <= 1'b0;
                        busy_r <= 1'b1;
                        op_r <= `SEC_OP_RELOAD;
                    end
                    else if (busy_r)
                    begin
                        cs_r <= 1'b1;
                        eng_start_r <= 1'b1;
                        eng_len_r <= flen(op_r);
                        eng_rd_r <= rd_op;
                        st_r <= S_SEND;
                        if (op_r == `SEC_OP_RELOAD)
                        begin
                            loading_r <= 1'b1;
                            lidx_r <= 3'h0;
                            ld_r <= 1'b0;
                            eng_tx_r <= frame(op_r, 7'h00, data_r);
                        end
                        else
                            eng_tx_r <= frame(op_r, loc_r, data_r);
                    end
                end
                S_SEND:
                begin
                    if (eng_done)
                    begin
                        cs_r <= 1'b0;
                        gap_r <= 3'h0;
                        st_r <= S_GAP;
                        if (loading_r)
                        begin
                            lidx_r <= lidx_r + 3'h1;
                            if (lidx_r == 3'h0)
                            begin
                                if (eng_rx != `SEC_SIG)
                                    loading_r <= 1'b0;
                            end
                            else
                            begin
                                o_station_addr[(lidx_r - 3'h1) * 8 +: 8] <= eng_rx;
                                if (lidx_r == `SEC_NBYTES)
                                begin
                                    loading_r <= 1'b0;
                                    ld_r <= 1'b1;
                                end
                            end
                        end
                        else if (op_r == `SEC_OP_READ)
                            data_r <= eng_rx;
                    end
                end
                S_GAP:
                begin
                    // chip select stays low for one half serial clock between frames
                    if (gap_r == GAP_LAST)
                    begin
                        if (poll_op)
                        begin
                            cs_r <= 1'b1;
                            tmo_r <= 21'h000000;
                            st_r <= S_POLL;
                        end
                        else if (loading_r)
                        begin
                            cs_r <= 1'b1;
                            eng_start_r <= 1'b1;
                            eng_tx_r <= frame(op_r, {4'h0, lidx_r}, data_r);
                            st_r <= S_SEND;
                        end
                        else
                        begin
                            busy_r <= 1'b0;
                            st_r <= S_IDLE;
                        end
                    end
                    else
                        gap_r <= gap_r + 3'h1;
                end
                S_POLL:
                begin
                    // the synchroniser needs a few cycles before data-out is current
                    tmo_r <= tmo_r + 21'h000001;
                    if (sdi_s && tmo_r > {18'h00000, GAP_LAST})
                    begin
                        cs_r <= 1'b0;
                        busy_r <= 1'b0;
                        st_r <= S_IDLE;
                    end
                    else if (tmo_r == TO_LAST)
                    begin
                        cs_r <= 1'b0;
                        to_r <= 1'b1;
                        busy_r <= 1'b0;
                        st_r <= S_IDLE;
                    end
                end
                default:
                    st_r <= S_IDLE;
            endcase
        end
    end

    // ****************************************
    // pin multiplexing
    // ****************************************
    always @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_sclk <= 1'b0;
            o_sdat <= 1'b0;
            o_sdat_oe <= 1'b0;
            o_scs <= 1'b0;
        end
        else if (i_ce)
        begin
            if (pcfg_r[`SEC_PC_EN])
            begin
                o_sclk <= eng_sclk;
                o_sdat <= eng_sdo;
                o_sdat_oe <= eng_oe;
                o_scs <= cs_r;
            end
            else
            begin
                // interface off: both pins are plain outputs or monitor taps
                o_sclk <= pcfg_r[`SEC_PC_CMON] ? i_mii_mon[1] : pcfg_r[`SEC_PC_CGPO];
                o_sdat <= pcfg_r[`SEC_PC_DMON] ? i_mii_mon[0] : pcfg_r[`SEC_PC_DGPO];
                o_sdat_oe <= 1'b1;
                o_scs <= 1'b0;
            end
        end
    end
endmodule

// file: sec_top_chk.sv
`timescale 1ns/10ps
// ****************************************
// bus and link checks
// ****************************************
module sec_top_chk #(
    parameter TO_CYCLES = 200
) (
    input wire i_clk_sys,
    input wire i_rst,
    input wire i_ce,
    input wire o_hreadyout,
    input wire o_hresp,
    input wire o_sdat,
    input wire o_sdat_oe,
    input wire o_sclk,
    input wire o_scs
);
    reg sclk_d;
    reg [4:0] nclk;
    reg [31:0] hi_cnt;
    // pins double as outputs when the interface is off, so link checks need cs
    always @(posedge i_clk_sys or posedge i_rst)
    if (i_rst)
    begin
        sclk_d <= 1'b0;
        nclk <= 5'h0;
        hi_cnt <= 32'h0;
    end
    else
    begin
        sclk_d <= o_sclk;
        nclk <= o_scs ? nclk + {4'h0, o_sclk & ~sclk_d} : 5'h0;
        hi_cnt <= o_scs ? hi_cnt + 32'h1 : 32'h0;
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst || !i_ce);
    a_ready_high: assert property (o_hreadyout) else $error("hready low");
    a_resp_okay: assert property (!o_hresp) else $error("hresp set");
    a_sclk_shape: assert property ($rose(o_sclk) && o_scs |-> o_sclk [*4] ##1 !o_sclk) else $error("sclk high");
    a_data_hold: assert property (o_scs && o_sclk && o_sdat_oe |-> $stable(o_sdat)) else $error("sdat moved");
    a_start_bit: assert property (o_scs && o_sclk && !sclk_d && nclk == 5'h0 |-> o_sdat) else $error("no start");
    a_frame_len: assert property ($fell(o_scs) |-> nclk == 5'h0 || nclk == 5'h0a || nclk == 5'h12) else $error("count");
    a_cs_gap: assert property ($fell(o_scs) |-> !o_scs [*4]) else $error("cs gap");
    a_poll_limit: assert property (o_scs |-> hi_cnt < TO_CYCLES) else $error("no timeout");
    cover property ($fell(o_scs) && nclk == 5'h12);
    cover property ($fell(o_scs) && nclk == 5'h0a);
    cover property (o_scs && hi_cnt == TO_CYCLES - 1);
endmodule
bind sec_top sec_top_chk #(.TO_CYCLES(TO_CYCLES)) sec_top_chk_inst (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(i_ce), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .o_sdat(o_sdat), .o_sdat_oe(o_sdat_oe), .o_sclk(o_sclk), .o_scs(o_scs)
);

// file: sec_top_tb_top.sv
`timescale 1ns/10ps
`include "sec_consts.vh"
module sec_top_tb_top;
    reg clk, rst, hsel, hwr, dead;
    reg [1:0] htr, mon;
    reg [31:0] hadr, hwd, rd;
    wire rdy, resp, sdo, oe, sclk, scs, sdi;
    wire [31:0] hrd;
    wire [47:0] sta;
    integer n_fail, samples_checked, cyc, i;
    // ****************************************
    // design and memory
    // ****************************************
    sec_top #(
        .TO_CYCLES(200)
    ) sec_top_inst (
        .i_clk_sys(clk), .i_rst(rst), .i_ce(1'b1), .i_hsel(hsel), .i_haddr(hadr), .i_htrans(htr),
        .i_hwrite(hwr), .i_hsize(3'h2), .i_hwdata(hwd), .i_hready(rdy), .o_hreadyout(rdy),
        .o_hresp(resp), .o_hrdata(hrd), .i_mii_mon(mon), .i_sdat(sdi), .o_sdat(sdo),
        .o_sdat_oe(oe), .o_sclk(sclk), .o_scs(scs), .o_station_addr(sta)
    );
    sec_mem_model sec_mem_model_inst (.sclk(sclk), .cs(scs), .di(sdo), .dead(dead), .do_o(sdi));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            n_fail = n_fail + 1;
            final_report;
        end
    end
    // ****************************************
    // bus and compare tasks
    // ****************************************
    task chk(input string nm, input [47:0] e, input [47:0] g);
    begin
        samples_checked = samples_checked + 1;
        if (g !== e)
        begin
            n_fail = n_fail + 1;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    end
    endtask
    task bus(input w, input [7:0] a, input [31:0] d);
    begin
        @(posedge clk);
        hsel <= 1'b1;
        hadr <= {24'h0, a};
        hwr <= w;
        htr <= 2'h2;
        do @(posedge clk); while (rdy !== 1'b1);
        hsel <= 1'b0;
        htr <= 2'h0;
        hwd <= d;
        do @(posedge clk); while (rdy !== 1'b1);
        rd = hrd;
    end
    endtask
    task wait_idle;
    begin
        bus(1'b0, `SEC_OFS_CMD, 32'h0);
        while (rd[31] !== 1'b0)
            bus(1'b0, `SEC_OFS_CMD, 32'h0);
    end
    endtask
    task cmd(input [2:0] op, input [6:0] loc, input [7:0] d);
    begin
        bus(1'b1, `SEC_OFS_DATA, {24'h0, d});
        bus(1'b1, `SEC_OFS_CMD, {1'b1, op, 21'h0, loc});
        wait_idle;
    end
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task t_rw;
    begin
        wait_idle;
        chk("station", 48'h161514131211, sta);
        chk("loaded", 48'h1, {47'h0, rd[8]});
        cmd(`SEC_OP_WEN, 7'h0, 8'h0);
        cmd(`SEC_OP_WRITE, 7'h7f, 8'h3c);
        chk("wr", 48'h3c, {40'h0, sec_mem_model_inst.mem[127]});
        cmd(`SEC_OP_READ, 7'h7f, 8'h0);
        bus(1'b0, `SEC_OFS_DATA, 32'h0);
        chk("rd", 48'h3c, {40'h0, rd[7:0]});
        cmd(`SEC_OP_ERASE, 7'h7f, 8'h0);
        chk("er", 48'hff, {40'h0, sec_mem_model_inst.mem[127]});
        cmd(`SEC_OP_WDIS, 7'h0, 8'h0);
        cmd(`SEC_OP_WRITE, 7'h5, 8'h0);
        chk("wdis", 48'h15, {40'h0, sec_mem_model_inst.mem[5]});
        cmd(`SEC_OP_WEN, 7'h0, 8'h0);
        cmd(`SEC_OP_WALL, 7'h0, 8'h5a);
        chk("write_all_cmd", 48'h5a5a, {32'h0, sec_mem_model_inst.mem[0], sec_mem_model_inst.mem[127]});
        cmd(`SEC_OP_EALL, 7'h0, 8'h0);
        chk("erase_all_cmd", 48'hff, {40'h0, sec_mem_model_inst.mem[64]});
        $display("t_rw done");
    end
    endtask
    task t_reload;
    begin
        cmd(`SEC_OP_RELOAD, 7'h0, 8'h0);
        chk("nold", 48'h0, {47'h0, rd[8]});
        chk("keep", 48'h161514131211, sta);
        cmd(`SEC_OP_WRITE, 7'h0, 8'ha5);
        cmd(`SEC_OP_WRITE, 7'h1, 8'h77);
        bus(1'b1, `SEC_OFS_CTRL, 32'h1);
        wait_idle;
        chk("soft", 48'hffffffffff77, sta);
        cmd(`SEC_OP_WRITE, 7'h2, 8'h66);
        cmd(`SEC_OP_RELOAD, 7'h0, 8'h0);
        chk("reld", 48'hffffffff6677, sta);
        chk("ld1", 48'h1, {47'h0, rd[8]});
        $display("t_reload done");
    end
    endtask
    task t_tout;
    begin
        dead = 1'b1;
        cmd(`SEC_OP_ERASE, 7'h3, 8'h0);
        chk("to", 48'h1, {47'h0, rd[9]});
        dead = 1'b0;
        bus(1'b1, `SEC_OFS_CMD, 32'h200);
        bus(1'b0, `SEC_OFS_CMD, 32'h0);
        chk("toclr", 48'h0, {47'h0, rd[9]});
        bus(1'b1, `SEC_OFS_PCFG, 32'h6);
        bus(1'b0, 8'h20, 32'h0);
        chk("unmap", 48'h0, {16'h0, rd});
        chk("gpo", 48'h7, {45'h0, oe, sdo, sclk});
        mon <= 2'h1;
        bus(1'b1, `SEC_OFS_PCFG, 32'h18);
        bus(1'b0, `SEC_OFS_CTRL, 32'h0);
        chk("ctl", 48'h0, {16'h0, rd});
        chk("mon", 48'h2, {46'h0, sdo, sclk});
        bus(1'b1, `SEC_OFS_PCFG, 32'h1);
        $display("t_tout done");
    end
    endtask
    task final_report;
    begin
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
    endtask
    initial
    begin
        n_fail = 0;
        samples_checked = 0;
        cyc = 0;
        rst = 1'b1;
        {hsel, hwr, dead, htr, mon, hadr, hwd, rd} = 0;
        sec_mem_model_inst.mem[0] = 8'ha5;
        for (i = 1; i < 7; i = i + 1)
            sec_mem_model_inst.mem[i] = 8'h10 + i[7:0];
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_rw;
        t_reload;
        t_tout;
        final_report;
    end
endmodule
